//--- include/link_cfg_pkg.sv
// link_cfg_pkg: register map, codes, timing and message table for the link
package link_cfg_pkg;

  localparam int AW = 11;
  localparam int DW = 16;

  // control and status words
  localparam logic [10:0] A_ERR  = 11'h01a;
  localparam logic [10:0] A_STAT = 11'h01c;
  localparam logic [10:0] A_TXST = 11'h01d;
  localparam logic [10:0] A_CMD  = 11'h01e;
  localparam logic [10:0] A_CTL  = 11'h01f;
  localparam logic [10:0] A_TXI  = 11'h046;
  localparam logic [10:0] A_TXB  = 11'h047;
  localparam logic [10:0] A_RXI  = 11'h04b;
  localparam logic [10:0] A_RXB  = 11'h04c;
  localparam logic [10:0] A_TMO  = 11'h050;
  localparam logic [10:0] A_SCAN = 11'h051;

  // data regions
  localparam logic [10:0] TXI_BASE = 11'h44c;
  localparam logic [10:0] TXB_BASE = 11'h578;
  localparam logic [10:0] RXI_BASE = 11'h064;
  localparam logic [10:0] RXB_BASE = 11'h190;
  localparam logic [15:0] MAX_WORDS = 16'h0100;
  localparam logic [15:0] MAX_BOOLW = 16'h0010;

  // field positions and reset value
  localparam int TXST_BUSY_BIT = 0;
  localparam int TXST_LINK_BIT = 1;
  localparam int CTL_RESET_BIT = 0;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // command codes
  localparam logic [15:0] CMD_MODE   = 16'h0002;
  localparam logic [15:0] CMD_ONLINE = 16'h0003;
  localparam logic [15:0] CMD_APPLY  = 16'h0004;
  localparam logic [15:0] CMD_OFFUPD = 16'h0080;

  // timing
  localparam int CLK_HZ  = 125_000_000;
  localparam int BAUD_HZ = 41_600;
  localparam logic [11:0] BAUD_DIV  = 12'(CLK_HZ / BAUD_HZ);
  localparam logic [11:0] BAUD_HALF = 12'(CLK_HZ / BAUD_HZ / 2);
  localparam int MS_UNIT_US = 1000;
  localparam int MS_CYCLES_DEFAULT = CLK_HZ / 1_000_000 * MS_UNIT_US;
  localparam logic [15:0] SCAN_MIN = 16'h000b;
  localparam logic [15:0] SCAN_MAX = 16'h00c6;

  // scan period -> {fixed ints, fixed bool words, words per message}
  function automatic logic [23:0] scan_table(input logic [15:0] scan);
    if (scan < 16'h0016) return {8'h07, 8'h01, 8'h0a};
    else if (scan < 16'h002c) return {8'h0c, 8'h02, 8'h12};
    else if (scan < 16'h0037) return {8'h12, 8'h03, 8'h1c};
    else if (scan < 16'h006e) return {8'h1e, 8'h04, 8'h2c};
    else return {8'h3c, 8'h08, 8'h50};
  endfunction

  function automatic logic [8:0] min9(input logic [15:0] a,
                                      input logic [15:0] b);
    return (a < b) ? a[8:0] : b[8:0];
  endfunction

  // count of packed 16-bit words needed for a count of booleans
  function automatic logic [15:0] bool_words(input logic [15:0] n);
    logic [16:0] s;
    s = {1'b0, n} + 17'h0000f;
    return {3'b000, s[16:4]};
  endfunction

endpackage

//--- logic/dp_word_mem.sv
// dp_word_mem: dual-port word bank with registered read data
`timescale 1ns/1ns
`default_nettype none
module dp_word_mem (
  input  wire logic        mclk_i,
  input  wire logic [10:0] a_addr_i,
  input  wire logic        a_we_i,
  input  wire logic [15:0] a_wdata_i,
  output logic      [15:0] a_rdata_o,
  input  wire logic [10:0] b_addr_i,
  input  wire logic        b_we_i,
  input  wire logic [15:0] b_wdata_i,
  output logic      [15:0] b_rdata_o
);
  logic [15:0] mem [0:2047];

  // both ports, link side wins on a same-word collision
  always_ff @(posedge mclk_i) begin
    if (a_we_i) mem[a_addr_i] <= a_wdata_i;
    if (b_we_i) mem[b_addr_i] <= b_wdata_i;
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end
endmodule // dp_word_mem
`default_nettype wire

//--- logic/serial_8o1.sv
// serial_8o1: asynchronous character transmitter and receiver, 8 data, odd
`timescale 1ns/1ns
`default_nettype none
module serial_8o1 (
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic       tx_start_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_busy_o,
  output logic            txd_o,
  input  wire logic       rxd_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_err_o
);
  import link_cfg_pkg::*;

  logic [9:0]  tx_sh;
  logic [11:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic        s1, s2, s3, rxf;
  logic        rx_act;
  logic [11:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [8:0]  rx_sh;

  // transmitter: start, 8 data lsb first, odd parity, one stop
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_busy_o <= 1'b0;
      txd_o     <= 1'b1;
      tx_sh     <= 10'h3ff;
      tx_cnt    <= 12'h000;
      tx_bit    <= 4'h0;
    end else if (!tx_busy_o) begin
      if (tx_start_i) begin
        tx_busy_o <= 1'b1;
        txd_o     <= 1'b0;
        tx_sh     <= {1'b1, ~^tx_data_i, tx_data_i};
        tx_cnt    <= 12'h000;
        tx_bit    <= 4'h0;
      end
    end else if (tx_cnt == BAUD_DIV - 12'h001) begin
      tx_cnt <= 12'h000;
      if (tx_bit == 4'ha) begin
        tx_busy_o <= 1'b0;
        txd_o     <= 1'b1;
      end else begin
        txd_o  <= tx_sh[0];
        tx_sh  <= {1'b1, tx_sh[9:1]};
        tx_bit <= tx_bit + 4'h1;
      end
    end else begin
      tx_cnt <= tx_cnt + 12'h001;
    end
  end

  // pin synchroniser, level taken once the last two stages agree
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1  <= 1'b1;
      s2  <= 1'b1;
      s3  <= 1'b1;
      rxf <= 1'b1;
    end else begin
      s1 <= rxd_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) rxf <= s3;
    end
  end

  // receiver, samples mid bit, flags parity, stop errors
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_act     <= 1'b0;
      rx_cnt     <= 12'h000;
      rx_bit     <= 4'h0;
      rx_sh      <= 9'h000;
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_err_o   <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rx_act) begin
        if (!rxf) begin
          rx_act <= 1'b1;
          rx_cnt <= BAUD_HALF;
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt == BAUD_DIV - 12'h001) begin
        rx_cnt <= 12'h000;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          if (rxf) rx_act <= 1'b0; // glitch, not a start bit
        end else if (rx_bit == 4'ha) begin
          rx_act     <= 1'b0;
          rx_valid_o <= 1'b1;
          rx_data_o  <= rx_sh[7:0];
          rx_err_o   <= !rxf || !(^rx_sh);
        end else begin
          rx_sh <= {rxf, rx_sh[8:1]};
        end
      end else begin
        rx_cnt <= rx_cnt + 12'h001;
      end
    end
  end
endmodule // serial_8o1
`default_nettype wire

//--- logic/link_command_config_port.sv
// link_command_config_port: host register bank, commands and link engine
`timescale 1ns/1ns
`default_nettype none
module link_command_config_port #(
  parameter int MS_CYCLES = link_cfg_pkg::MS_CYCLES_DEFAULT
) (
  input  wire logic                          mclk_i,
  input  wire logic                          arst_n_i,
  input  wire logic [link_cfg_pkg::AW-1:0]   host_addr_i,
  input  wire logic                          host_wr_i,
  input  wire logic                          host_rd_i,
  input  wire logic [link_cfg_pkg::DW-1:0]   host_wdata_i,
  output logic      [link_cfg_pkg::DW-1:0]   host_rdata_o,
  output logic                               host_rvalid_o,
  output logic                               txd_o,
  input  wire logic                          rxd_i,
  output logic                               tx_active_o,
  output logic                               link_ok_o
);
  import link_cfg_pkg::*;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_HDR   = 8'h02,
    S_FETCH = 8'h04,
    S_WAIT  = 8'h08,
    S_HI    = 8'h10,
    S_LO    = 8'h20,
    S_RX    = 8'h40,
    S_DONE  = 8'h80
  } eng_state_t;

  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

  eng_state_t  state;
  logic [15:0] err_cnt, drv_status, cmd_word, ctl_word;
  logic [15:0] cfg_txi, cfg_txb, cfg_rxi, cfg_rxb, cfg_tmo, cfg_scan;
  logic        link_ok, tx_active, ctl_prev;
  logic        ctl_hit, mem_a_we, rd_q, hit_q;
  logic [15:0] ctl_val, val_q, mem_a_rdata, mem_b_rdata;
  logic [8:0]  a_fi, a_fb, a_mint, a_mtot, a_mper, a_rxi, a_rxbw;
  logic [15:0] a_tmo;
  logic [8:0]  n_int, n_bw, t_fi, t_fb, t_rem, t_mtot;
  logic [23:0] tbl;
  logic [7:0]  cmd_q, rx_hi, tx_byte;
  logic [8:0]  widx, wtot, mux_ptr, next_mux, rx_idx, rx_tot, k;
  logic [15:0] word_q, ms_n;
  logic [16:0] ms_cnt;
  logic        rx_phase, in_mux, tx_go, tx_busy;
  logic        rx_valid, rx_err, rx_word, reply_ok, tmo_hit;
  logic        cmd_done, apply_go, clr_err, inc_err;
  logic [7:0]  rx_data;
  logic [10:0] rd_addr, wr_addr_q, b_addr;
  logic [15:0] wr_data_q;
  logic        wr_we_q;

  ////////////////////////////////////////////////////////////////////////////
  // host register bank

  // address decode of control words, everything else is the word bank
  always_comb begin
    ctl_hit = 1'b1;
    ctl_val = 16'h0000;
    if (host_addr_i == A_ERR) ctl_val = err_cnt;
    else if (host_addr_i == A_STAT) ctl_val = drv_status;
    else if (host_addr_i == A_TXST) begin
      ctl_val[TXST_BUSY_BIT] = tx_active;
      ctl_val[TXST_LINK_BIT] = link_ok;
    end
    else if (host_addr_i == A_CMD) ctl_val = cmd_word;
    else if (host_addr_i == A_CTL) ctl_val = ctl_word;
    else if (host_addr_i == A_TXI) ctl_val = cfg_txi;
    else if (host_addr_i == A_TXB) ctl_val = cfg_txb;
    else if (host_addr_i == A_RXI) ctl_val = cfg_rxi;
    else if (host_addr_i == A_RXB) ctl_val = cfg_rxb;
    else if (host_addr_i == A_TMO) ctl_val = cfg_tmo;
    else if (host_addr_i == A_SCAN) ctl_val = cfg_scan;
    else ctl_hit = 1'b0;
  end

  assign mem_a_we = host_wr_i && !ctl_hit;

  // configuration and control words written by the host
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_word <= REG_RESET;
      cfg_txi  <= REG_RESET;
      cfg_txb  <= REG_RESET;
      cfg_rxi  <= REG_RESET;
      cfg_rxb  <= REG_RESET;
      cfg_tmo  <= REG_RESET;
      cfg_scan <= REG_RESET;
    end else if (host_wr_i) begin
      if (host_addr_i == A_CTL) ctl_word <= host_wdata_i;
      else if (host_addr_i == A_TXI) cfg_txi <= host_wdata_i;
      else if (host_addr_i == A_TXB) cfg_txb <= host_wdata_i;
      else if (host_addr_i == A_RXI) cfg_rxi <= host_wdata_i;
      else if (host_addr_i == A_RXB) cfg_rxb <= host_wdata_i;
      else if (host_addr_i == A_TMO) cfg_tmo <= host_wdata_i;
      else if (host_addr_i == A_SCAN) cfg_scan <= host_wdata_i;
    end
  end

  // command word: host write, cleared when the engine finishes
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_word <= REG_RESET;
    end else if (host_wr_i && host_addr_i == A_CMD) begin
      cmd_word <= host_wdata_i;
    end else if (cmd_done) begin
      cmd_word <= REG_RESET;
    end
  end

  // two-stage read pipeline, every read answers on the second edge
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q          <= 1'b0;
      hit_q         <= 1'b0;
      val_q         <= 16'h0000;
      host_rvalid_o <= 1'b0;
      host_rdata_o  <= 16'h0000;
    end else begin
      rd_q          <= host_rd_i;
      hit_q         <= ctl_hit;
      val_q         <= ctl_val;
      host_rvalid_o <= rd_q;
      host_rdata_o  <= hit_q ? val_q : mem_a_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error count, link flag and transmit flag

  assign clr_err = ctl_prev && !ctl_word[CTL_RESET_BIT];
  assign inc_err = (rx_valid && rx_err) || tmo_hit;

  // error count, an error in the clearing cycle still counts
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_prev <= 1'b0;
      err_cnt  <= REG_RESET;
    end else begin
      ctl_prev <= ctl_word[CTL_RESET_BIT];
      if (inc_err) err_cnt <= (clr_err ? 16'h0000 : err_cnt) + 16'h0001;
      else if (clr_err) err_cnt <= 16'h0000;
    end
  end

  // link established flag and transmit activity
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_ok   <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      if (reply_ok) link_ok <= 1'b1;
      else if (tmo_hit) link_ok <= 1'b0;
      tx_active <= tx_busy || tx_go || state == S_HDR ||
                   state == S_FETCH || state == S_WAIT ||
                   state == S_HI || state == S_LO;
    end
  end

  assign tx_active_o = tx_active;
  assign link_ok_o   = link_ok;

  ////////////////////////////////////////////////////////////////////////////
  // applied configuration

  // message layout from counts and the scan period table
  always_comb begin
    tbl    = scan_table(cfg_scan);
    n_int  = min9(cfg_txi, MAX_WORDS);
    n_bw   = min9(bool_words(cfg_txb), MAX_BOOLW);
    t_fi   = min9({8'h00, tbl[23:16]}, {7'h00, n_int});
    t_fb   = min9({8'h00, tbl[15:8]}, {7'h00, n_bw});
    t_rem  = {1'b0, tbl[7:0]} - t_fi - t_fb;
    t_mtot = (n_int - t_fi) + (n_bw - t_fb);
  end

  assign apply_go = state == S_IDLE && cmd_word == CMD_APPLY;

  // copy of the configuration that the link actually uses
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_fi   <= 9'h000;
      a_fb   <= 9'h000;
      a_mint <= 9'h000;
      a_mtot <= 9'h000;
      a_mper <= 9'h000;
      a_rxi  <= 9'h000;
      a_rxbw <= 9'h000;
      a_tmo  <= 16'h0001;
    end else if (apply_go) begin
      a_fi   <= t_fi;
      a_fb   <= t_fb;
      a_mint <= n_int - t_fi;
      a_mtot <= t_mtot;
      a_mper <= min9({7'h00, t_rem}, {7'h00, t_mtot});
      a_rxi  <= min9(cfg_rxi, MAX_WORDS);
      a_rxbw <= min9(bool_words(cfg_rxb), MAX_BOOLW);
      a_tmo  <= (cfg_tmo == 16'h0000) ? 16'h0001 : cfg_tmo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link engine

  assign cmd_done = state == S_DONE;
  assign in_mux   = widx >= a_fi + a_fb;
  assign next_mux = (mux_ptr + 9'h001 == a_mtot) ? 9'h000
                                                 : mux_ptr + 9'h001;

  // source word: fixed ints, fixed bools, then the multiplexed window
  always_comb begin
    if (widx < a_fi) rd_addr = TXI_BASE + {2'b00, widx};
    else if (widx < a_fi + a_fb)
      rd_addr = TXB_BASE + {2'b00, widx - a_fi};
    else if (mux_ptr < a_mint)
      rd_addr = TXI_BASE + {2'b00, a_fi + mux_ptr};
    else
      rd_addr = TXB_BASE + {2'b00, a_fb + mux_ptr - a_mint};
  end

  // byte offered to the transmitter
  always_comb begin
    tx_go   = 1'b0;
    tx_byte = 8'h00;
    case (state)
      S_HDR: begin
        tx_go   = !tx_busy;
        tx_byte = cmd_q;
      end
      S_HI: begin
        tx_go   = !tx_busy;
        tx_byte = word_q[15:8];
      end
      S_LO: begin
        tx_go   = !tx_busy;
        tx_byte = word_q[7:0];
      end
      default: begin
        tx_go   = 1'b0;
        tx_byte = 8'h00;
      end
    endcase
  end

  assign rx_word  = state == S_RX && rx_valid && rx_phase;
  assign reply_ok = rx_word && rx_idx + 9'h001 == rx_tot;
  assign tmo_hit  = state == S_RX && ms_n >= a_tmo && !reply_ok;

  // command sequencer
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= S_IDLE;
      cmd_q    <= 8'h00;
      widx     <= 9'h000;
      wtot     <= 9'h000;
      mux_ptr  <= 9'h000;
      word_q   <= 16'h0000;
      rx_idx   <= 9'h000;
      rx_tot   <= 9'h000;
      rx_hi    <= 8'h00;
      rx_phase <= 1'b0;
    end else begin
      case (state)
        S_IDLE: if (cmd_word != 16'h0000) begin
          cmd_q    <= cmd_word[7:0];
          widx     <= 9'h000;
          rx_idx   <= 9'h000;
          rx_phase <= 1'b0;
          if (cmd_word == CMD_MODE || cmd_word == CMD_ONLINE) begin
            wtot   <= 9'h000;
            rx_tot <= 9'h001;
            state  <= S_HDR;
          end else if (cmd_word == CMD_OFFUPD) begin
            wtot   <= a_fi + a_fb + a_mper;
            rx_tot <= 9'h001 + a_rxi + a_rxbw;
            state  <= S_HDR;
          end else begin
            if (cmd_word == CMD_APPLY) mux_ptr <= 9'h000;
            state <= S_DONE;
          end
        end
        S_HDR: if (!tx_busy) begin
          state <= (wtot == 9'h000) ? S_RX : S_FETCH;
        end
        S_FETCH: state <= S_WAIT;
        S_WAIT: begin
          word_q <= mem_b_rdata;
          state  <= S_HI;
        end
        S_HI: if (!tx_busy) state <= S_LO;
        S_LO: if (!tx_busy) begin
          widx <= widx + 9'h001;
          if (in_mux) mux_ptr <= next_mux;
          state <= (widx + 9'h001 == wtot) ? S_RX : S_FETCH;
        end
        S_RX: begin
          if (rx_valid) begin
            rx_phase <= !rx_phase;
            if (!rx_phase) rx_hi <= rx_data;
            else rx_idx <= rx_idx + 9'h001;
          end
          if (reply_ok || tmo_hit) state <= S_DONE;
        end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // reply timer, milliseconds counted once the last byte is out
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ms_cnt <= 17'h00000;
      ms_n   <= 16'h0000;
    end else if (state != S_RX || tx_busy || rx_valid) begin
      ms_cnt <= 17'h00000;
      ms_n   <= 16'h0000;
    end else if (ms_cnt == MS_LAST) begin
      ms_cnt <= 17'h00000;
      ms_n   <= ms_n + 16'h0001;
    end else begin
      ms_cnt <= ms_cnt + 17'h00001;
    end
  end

  assign k = rx_idx - 9'h001;

  // reply words: status first, then received ints and bools
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_status <= REG_RESET;
      wr_we_q    <= 1'b0;
      wr_addr_q  <= 11'h000;
      wr_data_q  <= 16'h0000;
    end else begin
      wr_we_q <= 1'b0;
      if (rx_word && rx_idx == 9'h000) begin
        drv_status <= {rx_hi, rx_data};
      end else if (rx_word) begin
        wr_we_q   <= 1'b1;
        wr_data_q <= {rx_hi, rx_data};
        if (k < a_rxi) wr_addr_q <= RXI_BASE + {2'b00, k};
        else wr_addr_q <= RXB_BASE + {2'b00, k - a_rxi};
      end
    end
  end

  assign b_addr = (state == S_FETCH) ? rd_addr : wr_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // word bank and serial line

  dp_word_mem u_bank (
    .mclk_i    (mclk_i),
    .a_addr_i  (host_addr_i),
    .a_we_i    (mem_a_we),
    .a_wdata_i (host_wdata_i),
    .a_rdata_o (mem_a_rdata),
    .b_addr_i  (b_addr),
    .b_we_i    (wr_we_q),
    .b_wdata_i (wr_data_q),
    .b_rdata_o (mem_b_rdata)
  );

  // line rate from the baud divider
  serial_8o1 u_line (
    .mclk_i     (mclk_i),
    .arst_n_i   (arst_n_i),
    .tx_start_i (tx_go),
    .tx_data_i  (tx_byte),
    .tx_busy_o  (tx_busy),
    .txd_o      (txd_o),
    .rxd_i      (rxd_i),
    .rx_valid_o (rx_valid),
    .rx_data_o  (rx_data),
    .rx_err_o   (rx_err)
  );

endmodule // link_command_config_port
`default_nettype wire

//--- verification/link_port_asserts.sv
// link_port_asserts: port-level timing checks for the link port
`timescale 1ns/1ns
`default_nettype none
module link_port_asserts #(
  parameter int MS_CYCLES = 1
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic host_rvalid_o,
  input wire logic txd_o,
  input wire logic tx_active_o,
  input wire logic link_ok_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // host read answer timing
  a_rd_answer: assert property (host_rd_i |-> ##2 host_rvalid_o)
    else $error("read answer missing after two cycles");
  a_rd_spurious: assert property (
    host_rvalid_o |-> $past(host_rd_i, 2))
    else $error("read data marked without a read");
  // transmitter activity against the serial line
  a_start_active: assert property ($fell(txd_o) |-> tx_active_o)
    else $error("start bit while transmitter idle");
  a_start_low: assert property ($fell(txd_o) |=> !txd_o [*7])
    else $error("start bit too short");
  a_active_hold: assert property (
    $rose(tx_active_o) |=> tx_active_o [*8])
    else $error("transmit flag dropped early");
  a_idle_high: assert property ($fell(tx_active_o) |-> txd_o)
    else $error("line not idle when transmitter stops");
  // link flag moves only once the transmitter is idle
  a_link_rise: assert property ($rose(link_ok_o) |-> !tx_active_o)
    else $error("link flag rose while sending");
  a_link_fall: assert property ($fell(link_ok_o) |-> !tx_active_o)
    else $error("link flag fell while sending");
endmodule // link_port_asserts
bind link_command_config_port link_port_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_rvalid_o(host_rvalid_o), .txd_o(txd_o),
  .tx_active_o(tx_active_o), .link_ok_o(link_ok_o));
`default_nettype wire

//--- verification/link_drive_model.sv
// link_drive_model: remote drive that answers a frame with its status when the line is idle after the first character
`timescale 1ns/1ns
`default_nettype none
module link_drive_model (
  input  wire logic       mclk_i,
  input  wire logic       txd_i,
  output logic            rxd_o,
  output logic      [7:0] hdr_o
);
  import link_cfg_pkg::*;
  // one character: start, eight data lsb first, odd parity, stop
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge mclk_i) rxd_o = f[i];
      repeat (BAUD_DIV - 1) @(negedge mclk_i);
    end
  endtask
  // header byte sampled mid bit, then reply once the character has ended
  initial begin
    rxd_o = 1'b1;
    hdr_o = 8'h00;
    forever begin
      @(negedge txd_i);
      repeat (int'(BAUD_DIV) + int'(BAUD_HALF)) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        hdr_o[i] = txd_i;
        repeat (BAUD_DIV) @(posedge mclk_i);
      end
      repeat (int'(BAUD_DIV) + int'(BAUD_HALF) + 200) @(posedge mclk_i);
      if (txd_i) begin
        send(8'h00);
        send(8'h40);
      end
    end
  end
endmodule // link_drive_model
`default_nettype wire

//--- verification/test_link_command_config_port.sv
// test_link_command_config_port: register and command scenarios
`timescale 1ns/1ns
`default_nettype none
module test_link_command_config_port;
  import link_cfg_pkg::*;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [10:0] host_addr_i = 11'h000;
  logic        host_wr_i = 1'b0;
  logic        host_rd_i = 1'b0;
  logic [15:0] host_wdata_i = 16'h0000;
  logic [15:0] host_rdata_o;
  logic        host_rvalid_o, txd_o, rxd_i, tx_active_o, link_ok_o;
  logic        seen_act = 1'b0;
  logic [7:0]  hdr;
  logic [15:0] v;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [10:0] regs [11] = '{A_ERR, A_STAT, A_TXST, A_CMD, A_CTL, A_TXI,
                             A_TXB, A_RXI, A_RXB, A_TMO, A_SCAN};
  always #4 mclk_i = ~mclk_i;
  link_command_config_port #(.MS_CYCLES(2000)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .txd_o(txd_o), .rxd_i(rxd_i),
    .tx_active_o(tx_active_o), .link_ok_o(link_ok_o));
  link_drive_model peer (.mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i),
    .hdr_o(hdr));
  // remember any transmit activity
  always @(posedge mclk_i) if (tx_active_o === 1'b1) seen_act <= 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    {host_addr_i, host_wdata_i, host_wr_i} = {a, d, 1'b1};
    @(negedge mclk_i) host_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(negedge mclk_i);
    {host_addr_i, host_rd_i} = {a, 1'b1};
    @(negedge mclk_i) host_rd_i = 1'b0;
    @(negedge mclk_i);
    chk("rvalid", 16'h0001, {15'h0000, host_rvalid_o});
    d = host_rdata_o;
  endtask
  task automatic rc(input logic [10:0] a, input logic [15:0] e);
    logic [15:0] g;
    rd(a, g);
    chk($sformatf("word %h", a), e, g);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(negedge mclk_i);
    arst_n_i = 1'b1;
    foreach (regs[i]) rc(regs[i], REG_RESET);
    wr(A_ERR, 16'h1234);
    rc(A_ERR, 16'h0000);
    wr(A_TXI, 16'h00bb);
    rc(A_TXI, 16'h00bb);
    wr(A_RXI, 16'h0000);
    rc(A_RXI, 16'h0000);
    wr(TXI_BASE, 16'h5a5a);
    rc(TXI_BASE, 16'h5a5a);
    wr(A_TMO, 16'h0014);
    wr(A_SCAN, 16'h002c);
    wr(A_CMD, CMD_APPLY);
    rc(A_SCAN, 16'h002c);
    rc(A_CMD, 16'h0000);
    wr(A_CMD, 16'h0007);
    rc(A_TMO, 16'h0014);
    rc(A_CMD, 16'h0000);
    chk("activity", 16'h0000, {15'h0000, seen_act});
    wr(A_CTL, 16'h0001);
    wr(A_CTL, 16'h0000);
    rc(A_ERR, 16'h0000);
    wr(A_CMD, CMD_MODE);
    v = 16'hffff;
    for (int i = 0; i < 40000 && v !== 16'h0000; i++) rd(A_CMD, v);
    chk("command done", 16'h0000, v);
    if (v === 16'h0000) begin
      chk("activity", 16'h0001, {15'h0000, seen_act});
      chk("header", 16'h0002, {8'h00, hdr});
      rc(A_STAT, 16'h0040);
      rc(A_ERR, 16'h0000);
      rc(A_TXST, 16'h0002);
      chk("link", 16'h0001, {15'h0000, link_ok_o});
    end
    complete_run();
  end
endmodule // test_link_command_config_port
`default_nettype wire
